// File: touch_key_report.sv
// Key reporting, suppression groups, slider position, calibration and alert logic.
// Assumes scan results arrive synchronous to pclk, one strobe per matrix scan.
`timescale 1ns/1ns
module touch_key_report
  import touch_pkg::*;
#(
  parameter int INIT_CYC = INIT_CYCLES,
  parameter int RST_CYC  = RST_MIN_CYCLES
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // External reset pin, active low
  input  wire logic                 rst_pin_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Scan results
  input  wire touch_pkg::scan_t     scan,
  // Calibration request to acquisition
  output logic [NUM_KEYS-1:0]       cal_req,
  // Open-drain alert line
  output logic                      alert_o,
  output logic                      alert_oe
);
  import touch_pkg::*;

  typedef struct packed {
    phase_t                          phase;
    logic [31:0]                     timer;
    logic [15:0]                     rst_cnt;
    logic                            soft_rst;
    logic [3:0]                      scans;
    logic                            recal_en;
    logic [3:0]                      sl_len;
    logic [3:0]                      sl_res;
    logic [NUM_KEYS-1:0][1:0]        group;
    logic [15:0]                     neg_recal_delay;
    logic [11:0]                     neg_thr;
    logic [3:0]                      di_limit;
    logic [NUM_KEYS-1:0][3:0]        di_cnt;
    logic [NUM_KEYS-1:0][15:0]       hold;
    logic [NUM_KEYS-1:0]             detect;
    logic [NUM_KEYS-1:0]             report;
    logic [NUM_GROUPS:1][4:0]        owner;
    logic [7:0]                      pos;
    logic                            alert;
    logic [NUM_KEYS-1:0]             cal;
    logic [31:0]                     rdata;
  } state_t;

  state_t s_q, s_d;

  localparam logic [4:0] NO_OWNER = 5'h1f;
  localparam logic [4:0] SL_OBJ   = 5'h10;

  function automatic logic is_slider(input logic [3:0] len, input int k);
    is_slider = (k < SLIDER_MAX) && (k < int'(len));
  endfunction

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [NUM_KEYS-1:0] over;
  logic [NUM_KEYS-1:0] trig;
  logic [NUM_KEYS-1:0] pend;
  logic [11:0]         pos_thr;
  logic [DELTA_W+3:0]  wsum;
  logic [DELTA_W+3:0]  tsum;
  logic [15:0]         pos8;
  logic                sl_det;
  logic [NUM_KEYS-1:0] dom;
  logic [DELTA_W-1:0]  best;

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite;
  assign apb_rd  = apb_acc && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = s_q.rdata;
  assign alert_o  = 1'b0;
  assign alert_oe = s_q.alert;
  assign cal_req  = s_q.cal;
  assign pos_thr  = s_q.neg_thr - (s_q.neg_thr >> 2);

  always_comb begin
    s_d     = s_q;
    pslverr = 1'b0;
    over    = '0;
    trig    = '0;
    pend    = '0;
    wsum    = '0;
    tsum    = '0;
    pos8    = '0;
    sl_det  = 1'b0;
    dom     = '0;
    best    = '0;
    s_d.cal = '0;

    // Reset pin filter: only a long enough low pulse resets
    if (!rst_pin_n) begin
      if (s_q.rst_cnt < 16'(RST_CYC)) begin
        s_d.rst_cnt = s_q.rst_cnt + 16'h0001;
      end
    end else begin
      s_d.rst_cnt = '0;
    end
    s_d.soft_rst = rst_pin_n ? 1'b0 : (s_q.rst_cnt >= 16'(RST_CYC - 1));

    // APB register access
    if (apb_wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          s_d.recal_en = pwdata[CTRL_RECAL_EN];
        end
        ADDR_SLIDER: begin
          s_d.sl_len = pwdata[SL_LEN_LSB +: 4];
          s_d.sl_res = pwdata[SL_RES_LSB +: 4];
        end
        ADDR_GROUP: begin
          for (int k = 0; k < NUM_KEYS; k++) begin
            s_d.group[k] = pwdata[2*k +: 2];
          end
        end
        ADDR_NRD: begin
          s_d.neg_recal_delay = pwdata[15:0];
        end
        ADDR_THR: begin
          s_d.neg_thr  = pwdata[THR_NEG_LSB +: 12];
          s_d.di_limit = pwdata[THR_DI_LSB +: 4];
        end
        default: begin
          pslverr = !(paddr == ADDR_STATUS || paddr == ADDR_POS || paddr == ADDR_GEN);
        end
      endcase
    end
    // Read word captured in setup so it stands at the access edge
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL:   s_d.rdata = {31'h0, s_q.recal_en};
        ADDR_SLIDER: s_d.rdata = {24'h0, s_q.sl_res, s_q.sl_len};
        ADDR_GROUP:  s_d.rdata = s_q.group;
        ADDR_NRD:    s_d.rdata = {16'h0, s_q.neg_recal_delay};
        ADDR_THR:    s_d.rdata = {12'h0, s_q.di_limit, 4'h0, s_q.neg_thr};
        ADDR_STATUS: s_d.rdata = {16'h0, s_q.report};
        ADDR_POS:    s_d.rdata = {24'h0, s_q.pos};
        ADDR_GEN:    s_d.rdata = {29'h0, s_q.alert, s_q.phase};
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    if (apb_rd) begin
      pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_SLIDER || paddr == ADDR_GROUP || paddr == ADDR_NRD ||
                  paddr == ADDR_THR || paddr == ADDR_STATUS || paddr == ADDR_POS || paddr == ADDR_GEN);
    end

    // Status read releases the alert
    if (apb_rd && (paddr == ADDR_STATUS || paddr == ADDR_POS)) begin
      s_d.alert = 1'b0;
    end

    unique case (s_q.phase)
      ST_INIT: begin
        s_d.timer = s_q.timer + 32'h1;
        if (s_q.timer >= 32'(INIT_CYC - 1)) begin
          s_d.phase = ST_CAL;
          s_d.alert = 1'b1;
          s_d.scans = '0;
          s_d.cal   = '1;
        end
      end
      ST_CAL: begin
        if (scan.valid) begin
          s_d.scans = s_q.scans + 4'h1;
          if (s_q.scans == CAL_SCANS - 4'h1) begin
            s_d.phase = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (scan.valid) begin
          // Integrator per key
          for (int k = 0; k < NUM_KEYS; k++) begin
            over[k] = scan.delta[k] > s_q.neg_thr;
            if (!over[k]) begin
              s_d.di_cnt[k] = '0;
            end else if (s_q.di_cnt[k] < s_q.di_limit) begin
              s_d.di_cnt[k] = s_q.di_cnt[k] + 4'h1;
            end
            s_d.detect[k] = over[k] && ({1'b0, s_q.di_cnt[k]} + 5'h01 >= {1'b0, s_q.di_limit});
            if (s_d.detect[k]) begin
              s_d.hold[k] = s_q.hold[k] + 16'h1;
            end else begin
              s_d.hold[k] = '0;
            end
            // Recalibration triggers
            trig[k] = s_q.recal_en &&
                      ((s_q.detect[k] && s_q.hold[k] >= s_q.neg_recal_delay) ||
                       (scan.delta[k] > DELTA_W'(pos_thr)));
            if (trig[k]) begin
              s_d.cal[k]    = 1'b1;
              s_d.detect[k] = 1'b0;
              s_d.di_cnt[k] = '0;
              s_d.hold[k]   = '0;
            end
            if (is_slider(s_q.sl_len, k) && s_d.detect[k]) begin
              sl_det = 1'b1;
            end
          end

          // Group suppression with slider as one object
          for (int g = 1; g <= NUM_GROUPS; g++) begin
            // Release owner once it leaves detect
            if (s_q.owner[g] == SL_OBJ) begin
              if (!sl_det) s_d.owner[g] = NO_OWNER;
            end else if (s_q.owner[g] != NO_OWNER) begin
              if (!s_d.detect[s_q.owner[g][3:0]]) s_d.owner[g] = NO_OWNER;
            end
            if (s_d.owner[g] == NO_OWNER) begin
              best = '0;
              for (int k = 0; k < NUM_KEYS; k++) begin
                if (s_d.detect[k] && s_q.group[k] == 2'(g) && scan.delta[k] > best) begin
                  best = scan.delta[k];
                  s_d.owner[g] = is_slider(s_q.sl_len, k) ? SL_OBJ : 5'(k);
                end
              end
            end
          end
          for (int k = 0; k < NUM_KEYS; k++) begin
            if (s_q.group[k] == 2'h0) begin
              pend[k] = s_d.detect[k];
            end else if (is_slider(s_q.sl_len, k)) begin
              pend[k] = s_d.detect[k] && s_d.owner[s_q.group[k]] == SL_OBJ;
            end else begin
              pend[k] = s_d.detect[k] && s_d.owner[s_q.group[k]] == 5'(k);
            end
          end
          s_d.report = pend;

          // Slider position: weighted centroid of slider deltas
          for (int k = 0; k < SLIDER_MAX; k++) begin
            if (is_slider(s_q.sl_len, k) && pend[k]) begin
              wsum = wsum + (DELTA_W+4)'(scan.delta[k]) * (DELTA_W+4)'(k);
              tsum = tsum + (DELTA_W+4)'(scan.delta[k]);
            end
          end
          if (tsum != '0 && s_q.sl_len > 4'h1) begin
            pos8 = 16'((32'(wsum) * 32'h0ff) / (32'(tsum) * 32'(s_q.sl_len - 4'h1)));
            s_d.pos = pos8[7:0] >> (4'h8 - ((s_q.sl_res < 4'h2) ? 4'h2 :
                                   (s_q.sl_res > 4'h8) ? 4'h8 : s_q.sl_res));
          end
          if (s_d.report != s_q.report || s_d.pos != s_q.pos) begin
            s_d.alert = 1'b1;
          end
          if (|trig && |s_q.report) begin
            s_d.alert = 1'b1;
          end
        end
      end
      default: begin
        s_d.phase = ST_INIT;
      end
    endcase

    // Host command: fresh calibration of all keys
    if (apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_RECAL_CMD]) begin
      s_d.phase  = ST_CAL;
      s_d.scans  = '0;
      s_d.cal    = '1;
      s_d.detect = '0;
      s_d.di_cnt = '0;
      s_d.hold   = '0;
      s_d.report = '0;
      for (int g = 1; g <= NUM_GROUPS; g++) s_d.owner[g] = NO_OWNER;
      if (|s_q.report) begin
        s_d.alert = 1'b1;
      end
    end

    // Filtered pin reset equals power-up
    if (s_q.soft_rst) begin
      s_d = '0;
      s_d.sl_len   = SL_LEN_RST;
      s_d.sl_res   = SL_RES_RST;
      s_d.neg_recal_delay      = NRD_RST;
      s_d.neg_thr  = NEG_THR_RST;
      s_d.di_limit = DI_LIMIT_RST;
      for (int g = 1; g <= NUM_GROUPS; g++) s_d.owner[g] = NO_OWNER;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.sl_len   <= SL_LEN_RST;
      s_q.sl_res   <= SL_RES_RST;
      s_q.neg_recal_delay      <= NRD_RST;
      s_q.neg_thr  <= NEG_THR_RST;
      s_q.di_limit <= DI_LIMIT_RST;
      s_q.owner    <= '1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // touch_key_report

// File: touch_pkg.sv
// Constants, register map and carrier types for the touch key report block.
// Assumes a single 100 MHz clock domain and an APB register bus.
package touch_pkg;

  localparam int          CLK_MHZ        = 100;
  localparam int          NUM_KEYS       = 16;
  localparam int          SLIDER_MAX     = 8;
  localparam int          DELTA_W        = 12;
  localparam int          NUM_GROUPS     = 3;

  // Timing
  localparam int          INIT_TIME_MS   = 70;
  localparam int          INIT_CYCLES    = INIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int          RST_MIN_US     = 10;
  localparam int          RST_MIN_CYCLES = RST_MIN_US * CLK_MHZ;
  localparam logic [3:0]  CAL_SCANS      = 4'hf;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_SLIDER    = 8'h04;
  localparam logic [7:0]  ADDR_GROUP     = 8'h08;
  localparam logic [7:0]  ADDR_NRD       = 8'h0c;
  localparam logic [7:0]  ADDR_THR       = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam logic [7:0]  ADDR_POS       = 8'h18;
  localparam logic [7:0]  ADDR_GEN       = 8'h1c;

  // Control fields
  localparam int          CTRL_RECAL_EN  = 0;
  localparam int          CTRL_RECAL_CMD = 1;
  localparam int          SL_LEN_LSB     = 0;
  localparam int          SL_RES_LSB     = 4;
  localparam int          THR_NEG_LSB    = 0;
  localparam int          THR_DI_LSB     = 16;

  // Reset values
  localparam logic [3:0]  SL_LEN_RST     = 4'h0;
  localparam logic [3:0]  SL_RES_RST     = 4'h8;
  localparam logic [11:0] NEG_THR_RST    = 12'h00a;
  localparam logic [3:0]  DI_LIMIT_RST   = 4'h4;
  localparam logic [15:0] NRD_RST        = 16'h0064;

  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_CAL   = 2'b01,
    ST_RUN   = 2'b10
  } phase_t;

  // One scan result from the acquisition front end
  typedef struct packed {
    logic                                valid;
    logic [NUM_KEYS-1:0][DELTA_W-1:0]    delta;
  } scan_t;

endpackage

// File: touch_key_report_asserts.sv
// Checker for the touch key report block.
// Bound to touch_key_report, sees its ports only.
`timescale 1ns/1ns
module touch_key_report_asserts
  import touch_pkg::*;
#(
  parameter int INIT_CYC = 50,
  parameter int RST_CYC  = 20
) (
  // Clock and resets
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                rst_pin_n,
  // APB request
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  // Scan, calibration, alert
  input wire touch_pkg::scan_t    scan,
  input wire logic [NUM_KEYS-1:0] cal_req,
  input wire logic                alert_oe
);
  // ***
  // Startup and pin reset counters
  // ***
  int   ic_q;
  int   lo_q;
  logic rd_w;
  logic cmd_w;
  assign rd_w  = psel && penable && !pwrite && (paddr == ADDR_STATUS || paddr == ADDR_POS);
  assign cmd_w = psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_RECAL_CMD];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic_q <= 0;
      lo_q <= 0;
    end else begin
      lo_q <= rst_pin_n ? 0 : (lo_q > RST_CYC ? lo_q : lo_q + 1);
      ic_q <= (lo_q == RST_CYC) ? 0 : (ic_q > INIT_CYC + 20 ? ic_q : ic_q + 1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_INIT_QUIET: assert property (ic_q + 3 < INIT_CYC |-> !alert_oe && cal_req == '0)
    else $error("Alert or calibration during startup");
  AST_INIT_ALERT: assert property (ic_q == INIT_CYC - 2 |-> ##[1:8] alert_oe)
    else $error("No alert after startup");
  AST_INIT_CAL: assert property (ic_q == INIT_CYC - 2 |-> ##[1:8] cal_req == {NUM_KEYS{1'b1}})
    else $error("No calibration after startup");
  AST_ALERT_HOLD: assert property (alert_oe && !rd_w && rst_pin_n && $past(rst_pin_n) && $past(rst_pin_n, 2)
    |=> alert_oe)
    else $error("Alert released without status read");
  AST_ALERT_CAUSE: assert property ($rose(alert_oe) |-> (ic_q inside {[INIT_CYC-2:INIT_CYC+8]})
    || $past(scan.valid) || $past(scan.valid, 2) || $past(scan.valid, 3) || $past(cmd_w) || $past(cmd_w, 2))
    else $error("Alert without cause");
  AST_CMD_CAL: assert property (cmd_w |-> ##[1:3] cal_req == {NUM_KEYS{1'b1}})
    else $error("Command did not start calibration");
  AST_CAL_PULSE: assert property (cal_req != '0 |=> cal_req == '0)
    else $error("Calibration request not a pulse");
  AST_PIN_RESET: assert property (lo_q == RST_CYC |-> ##[1:3] !alert_oe && cal_req == '0)
    else $error("Pin reset ignored");
  cover property (cmd_w ##[1:3] cal_req != '0);
  cover property (lo_q == RST_CYC);
  cover property (rd_w && alert_oe ##1 !alert_oe);
endmodule // touch_key_report_asserts

bind touch_key_report touch_key_report_asserts #(.INIT_CYC(INIT_CYC), .RST_CYC(RST_CYC)) touch_key_report_asserts_inst (
  .pclk(pclk), .presetn(presetn), .rst_pin_n(rst_pin_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .scan(scan), .cal_req(cal_req), .alert_oe(alert_oe));

// File: touch_host_model.sv
// Host side of the open-drain alert line.
// Assumes a pull-up resistor on the line.
`timescale 1ns/1ns
module touch_host_model (
  // Device pin drive
  input  wire logic alert_o,
  input  wire logic alert_oe,
  // Level the host sees
  output logic      alert_n
);
  // Pull-up when released
  assign alert_n = alert_oe ? alert_o : 1'b1;
endmodule // touch_host_model

// File: touch_key_report_tb_top.sv
// Self-checking bench for the touch key report block.
// Bench plays the host and the scan front end.
`timescale 1ns/1ns
module touch_key_report_tb_top;
  import touch_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t mismatch", $time); end end
  // ***
  // Signals and instances
  // ***
  logic                             pclk, presetn, rst_pin_n, psel, penable, pwrite, pready, pslverr;
  logic                             alert_o, alert_oe, alert_n;
  logic                             rd_fire = 1'b0;
  logic [7:0]                       paddr;
  logic [31:0]                      pwdata, prdata;
  logic [15:0]                      cal_req, cal_last;
  logic [63:0]                      exp_q[$];
  logic [63:0]                      e;
  logic [NUM_KEYS-1:0][DELTA_W-1:0] d;
  logic [11:0]                      t;
  scan_t                            sc;
  int                               n_errors, tests_run, cal_n, n0;
  integer                           seed;
  always #5 pclk = ~pclk;
  touch_key_report #(.INIT_CYC(50), .RST_CYC(20)) touch_key_report_inst (.pclk(pclk), .presetn(presetn),
    .rst_pin_n(rst_pin_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan(sc), .cal_req(cal_req), .alert_o(alert_o),
    .alert_oe(alert_oe));
  touch_host_model touch_host_model_inst (.alert_o(alert_o), .alert_oe(alert_oe), .alert_n(alert_n));
  // Read data stands at the access edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      `CHK(prdata & e[63:32], e[31:0])
    end
    if (cal_req !== 16'h0) begin
      cal_n++;
      cal_last = cal_req;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back({m, v & m});
    @(posedge pclk);
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) begin
      `CHK(1'b0, 1'b1)
      complete_run();
    end
    `CHK(pslverr, a > ADDR_GEN)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic scans(input int n);
    repeat (n) begin
      sc.valid <= 1'b1;
      sc.delta <= d;
      @(posedge pclk);
      sc.valid <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask
  task automatic pin(input int n);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    rst_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_alert(input logic lvl);
    int k;
    for (k = 0; k < 300 && alert_n !== lvl; k++) @(posedge pclk);
    `CHK(alert_n, lvl)
  endtask
  task automatic complete_run();
    $display("Errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***
  // Main sequence
  // ***
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, sc, d} = '0;
    rst_pin_n = 1'b1;
    seed = 32'hb0e3;
    t = 12'h20 | 12'($random(seed) & 31);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_SLIDER, 32'h80, 32'hff);
    apb(0, ADDR_THR, 32'h4000a, 32'hf0fff);
    apb(0, 8'h20, 0, 32'hffffffff);
    apb(0, ADDR_GEN, 0, 3);
    wait_alert(0);
    apb(0, ADDR_STATUS, 0, 32'hffff);
    wait_alert(1);
    scans(14);
    apb(0, ADDR_GEN, 1, 3);
    scans(1);
    apb(0, ADDR_GEN, 2, 7);
    apb(1, ADDR_SLIDER, 32'h83, 0);
    apb(1, ADDR_GROUP, 32'h2855, 0);
    apb(1, ADDR_THR, 32'h2000a, 0);
    apb(1, ADDR_NRD, 3, 0);
    d[8] = t;
    scans(1);
    d[8] = 0;
    scans(1);
    d[8] = t;
    scans(1);
    apb(0, ADDR_STATUS, 0, 32'hffff);
    scans(1);
    wait_alert(0);
    apb(0, ADDR_STATUS, 32'h100, 32'hffff);
    n0 = cal_n;
    scans(6);
    `CHK(cal_n, n0)
    {d[3], d[5], d[6], d[9]} = {t, t + 12'h10, t, t};
    scans(2);
    {d[0], d[1]} = {t, t};
    scans(2);
    apb(0, ADDR_STATUS, 32'h328, 32'hffff);
    d = '0;
    scans(2);
    {d[0], d[1], d[2]} = {t, t, t};
    scans(2);
    d[3] = t;
    scans(2);
    apb(0, ADDR_STATUS, 32'h7, 32'hffff);
    apb(0, ADDR_POS, 32'h7f, 32'hff);
    apb(1, ADDR_SLIDER, 32'h23, 0);
    scans(1);
    apb(0, ADDR_POS, 1, 32'hff);
    d = '0;
    d[8] = t;
    apb(1, ADDR_CTRL, 1, 0);
    n0 = cal_n;
    scans(8);
    `CHK(cal_last, 16'h0100)
    `CHK(cal_n > n0, 1'b1)
    apb(1, ADDR_CTRL, 0, 0);
    scans(2);
    apb(0, ADDR_STATUS, 32'h100, 32'hffff);
    apb(1, ADDR_CTRL, 2, 0);
    scans(15);
    wait_alert(0);
    d = '0;
    scans(3);
    apb(0, ADDR_STATUS, 0, 0);
    apb(1, ADDR_CTRL, 2, 0);
    scans(15);
    wait_alert(1);
    pin(19);
    apb(0, ADDR_SLIDER, 32'h23, 32'hff);
    pin(20);
    apb(0, ADDR_SLIDER, 32'h80, 32'hff);
    apb(0, ADDR_GEN, 0, 7);
    wait_alert(0);
    complete_run();
  end
endmodule // touch_key_report_tb_top
